/* cts_frame_model.sv */
// Purpose: frame engine stand-in giving bit ticks and tx scans
// Assumes: a scan starts on a kick and lasts SCAN cycles
// Notes:   scan end reports every buffer requested meanwhile
`timescale 1ns/1ps
module cts_frame_model #(
   parameter int DIV  = 1,
   parameter int SCAN = 40
) (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   // scan start and requests seen
   input  wire logic        i_kick,
   input  wire logic [31:0] i_req,
   // to the block
   output logic             o_tick,
   output logic             o_busy,
   output logic [31:0]      o_done
);
   int          div_c;
   int          scan_c;
   logic [31:0] pend;
   assign o_busy = scan_c != 0;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         div_c <= 0;
         scan_c <= 0;
         o_tick <= 1'b0;
         pend <= 32'h0;
         o_done <= 32'h0;
      end else begin
         div_c <= (div_c == DIV - 1) ? 0 : div_c + 1;
         o_tick <= div_c == DIV - 1;
         o_done <= 32'h0;
         pend <= pend | i_req;
         scan_c <= i_kick ? SCAN : (scan_c > 0 ? scan_c - 1 : 0);
         if (scan_c == 1) begin
            o_done <= pend | i_req;
            pend <= 32'h0;
         end
      end
   end
endmodule : cts_frame_model

/* cts_pkg.sv */
// Purpose: constants for the can timestamp and transmit request block
// Assumes: classic wishbone slave, 32-bit data, one clock at 50 MHz
// Notes:   offsets are byte addresses
package cts_pkg;
   localparam logic [7:0]  ADR_CORE_CTRL   = 8'h18;
   localparam logic [7:0]  ADR_STAMP_CFG   = 8'h20;
   localparam logic [7:0]  ADR_STAMP_VAL   = 8'h24;
   localparam logic [7:0]  ADR_IRQ_STATUS  = 8'h50;
   localparam logic [7:0]  ADR_IRQ_MASK    = 8'h54;
   localparam logic [7:0]  ADR_BUF_CONFIG  = 8'hC0;
   localparam logic [7:0]  ADR_TX_ADD_REQ  = 8'hD0;
   localparam int          CFG_HOLD_BIT    = 0;
   localparam int          CLK_STOP_REQ_BIT = 4;
   localparam int          CLK_STOP_ACK_BIT = 3;
   localparam int          PRESCALE_LSB    = 16;
   localparam int          SRC_LSB         = 0;
   localparam logic [1:0]  SRC_INTERNAL    = 2'h1;
   localparam logic [1:0]  SRC_EXTERNAL    = 2'h2;
   localparam int          STAMP_W         = 16;
   localparam int          SYNC_STAGES     = 3;
   localparam logic [1:0]  IRQ_WRAP        = 2'h1;
   localparam logic [1:0]  IRQ_STOP_EXIT   = 2'h2;
   localparam logic [31:0] CORE_CTRL_RST   = 32'h0000_0001;
endpackage : cts_pkg

/* cts_props.sv */
// Purpose: port checker for the can timestamp and tx request block
// Assumes: one clock, async active-low reset, one-cycle wishbone ack
// Notes:   write to core ctrl counted from the edge that takes it
`timescale 1ns/1ps
module cts_props
   import cts_pkg::*;
(
   // clock and reset
   input wire logic        i_clk,
   input wire logic        i_nrst,
   // wishbone
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic        i_wb_we,
   input wire logic [7:0]  i_wb_adr,
   input wire logic [3:0]  i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic [31:0] o_wb_dat,
   input wire logic        o_wb_ack,
   // frame engine and irq
   input wire logic        i_bit_tick,
   input wire logic        i_scan_busy,
   input wire logic [31:0] i_scan_done,
   input wire logic [31:0] o_tx_request,
   input wire logic        o_cfg_hold,
   input wire logic        o_clk_stop_ack,
   input wire logic        o_irq
);
   logic       take;
   logic [3:0] since;
   logic [1:0] src;
   assign take = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         since <= 4'hf;
      end else if (take && i_wb_we && i_wb_adr == ADR_CORE_CTRL) begin
         since <= 4'h0;
      end else if (since != 4'hf) begin
         since <= since + 4'h1;
      end
   end
   // shadow of the source field, so a read of the counter can be judged
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         src <= 2'h0;
      end else if (take && i_wb_we && i_wb_adr == ADR_STAMP_CFG && i_wb_sel[0]) begin
         src <= i_wb_dat[1:0];
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   AST_ACK_LAT: assert property (take |=> o_wb_ack) else $error("ack late");
   AST_ACK_ONE: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
   AST_ACK_REQ: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
      else $error("ack without request");
   AST_TXREQ: assert property (|o_tx_request |->
      (o_tx_request & ~$past(i_wb_dat)) == 32'h0 && $past(i_wb_adr) == ADR_TX_ADD_REQ)
      else $error("request bit not written");
   AST_STOP_CAUSE: assert property ($changed(o_clk_stop_ack) |-> since inside {[1:8]})
      else $error("stop ack moved alone");
   AST_STOP_EXIT: assert property (take && i_wb_we && i_wb_adr == ADR_CORE_CTRL
      && !i_wb_dat[CLK_STOP_REQ_BIT] && o_clk_stop_ack && since > 4'h8
      |-> ##[1:8] !o_clk_stop_ack) else $error("stop ack kept");
   AST_HOLD_LATE: assert property ($changed(o_cfg_hold) |-> since inside {[2:8]})
      else $error("hold not synchronized");
   AST_STAMP_ZERO: assert property (o_wb_ack
      && $past(!i_wb_we && i_wb_adr == ADR_STAMP_VAL)
      && (src == 2'h0 || src == 2'h3) |-> o_wb_dat == 32'h0)
      else $error("counter not held at zero");
endmodule : cts_props

bind cts_top cts_props props_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc),
   .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
   .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_bit_tick(i_bit_tick),
   .i_scan_busy(i_scan_busy), .i_scan_done(i_scan_done), .o_tx_request(o_tx_request),
   .o_cfg_hold(o_cfg_hold), .o_clk_stop_ack(o_clk_stop_ack), .o_irq(o_irq));

/* cts_stamp.sv */
// Purpose: prescaled 16-bit timestamp counter with wrap detection
// Assumes: i_bit_tick pulses once per can bit time
// Notes:   external mode keeps the counter at its last value here
`timescale 1ns/1ps
module cts_stamp
   import cts_pkg::*;
(
   // clock and reset
   input  wire logic               i_clk,
   input  wire logic               i_nrst,
   // control
   input  wire logic               i_bit_tick,
   input  wire logic [3:0]         i_prescale,
   input  wire logic [1:0]         i_src,
   input  wire logic               i_clear_wr,
   // status
   output logic      [STAMP_W-1:0] o_value,
   output logic                    o_wrap
);
   logic [3:0] unit_cnt;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         unit_cnt <= 4'h0;
         o_value  <= '0;
         o_wrap   <= 1'b0;
      end else begin
         o_wrap <= 1'b0;
         if (i_src != SRC_INTERNAL && i_src != SRC_EXTERNAL) begin
            o_value  <= '0;
            unit_cnt <= 4'h0;
         end else if (i_src == SRC_INTERNAL && i_clear_wr) begin
            o_value  <= '0;
            unit_cnt <= 4'h0;
         end else if (i_src == SRC_INTERNAL && i_bit_tick) begin
            if (unit_cnt >= i_prescale) begin
               unit_cnt <= 4'h0;
               o_value  <= o_value + 1'b1;
               o_wrap   <= (o_value == {STAMP_W{1'b1}});
            end else begin
               unit_cnt <= unit_cnt + 4'h1;
            end
         end
         // external source or ignored write keeps the value
      end
   end
endmodule : cts_stamp

/* cts_sync.sv */
// Purpose: write synchronizer for one bit into the core clock side
// Assumes: core domain modelled as a fixed stage delay on the one clock
// Notes:   busy stays high until the new value has landed
`timescale 1ns/1ps
module cts_sync
   import cts_pkg::*;
(
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_nrst,
   // write side
   input  wire logic i_wr,
   input  wire logic i_val,
   // result
   output logic      o_val,
   output logic      o_busy
);
   logic [SYNC_STAGES-1:0] pipe;
   logic                   pend;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pipe   <= '0;
         pend   <= 1'b0;
         o_val  <= 1'b1;
         o_busy <= 1'b0;
      end else begin
         // new writes during busy are dropped, as a bus error would be
         if (i_wr && !o_busy) begin
            pend   <= i_val;
            pipe   <= {{(SYNC_STAGES-1){1'b0}}, 1'b1};
            o_busy <= 1'b1;
         end else if (o_busy) begin
            pipe <= {pipe[SYNC_STAGES-2:0], 1'b0};
            if (pipe[SYNC_STAGES-1]) begin
               o_val  <= pend;
               o_busy <= 1'b0;
            end
         end
      end
   end
endmodule : cts_sync

/* cts_top.sv */
// Purpose: can timestamp, clock stop exit, write sync and tx add request
// Assumes: classic wishbone slave, single clock, synchronous inputs
// Notes:   one-cycle ack after the request is seen, zero wait reads
`timescale 1ns/1ps
module cts_top
   import cts_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   // wishbone slave
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   // link to frame engine
   input  wire logic        i_bit_tick,
   input  wire logic        i_scan_busy,
   input  wire logic [31:0] i_scan_done,
   output logic      [31:0] o_tx_request,
   output logic             o_cfg_hold,
   output logic             o_clk_stop_ack,
   // interrupt
   output logic             o_irq
);
   logic [31:0]        core_ctrl;
   logic [3:0]         stamp_prescale;
   logic [1:0]         stamp_source_select;
   logic [31:0]        transmit_buffer_config;
   logic [31:0]        transmit_add_request;
   logic [1:0]         irq_status;
   logic [1:0]         irq_mask;
   logic               clock_stop_request;
   logic               clock_stop_ack;
   logic               hold_val;
   logic               hold_busy;
   logic [STAMP_W-1:0] stamp_value;
   logic               stamp_wrap;
   logic               wr_en;
   logic [31:0]        wmask;
   logic [31:0]        next_rdata;
   logic               stop_exit;

   function automatic logic [31:0] lane_mask(input logic [3:0] sel);
      lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction : lane_mask

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [31:0] m);
      merge = (old_v & ~m) | (new_v & m);
   endfunction : merge

   assign wr_en = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
   assign wmask = lane_mask(i_wb_sel);

   // ack one cycle after request, dropped the next cycle
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_wb_ack <= 1'b0;
      end else begin
         o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
      end
   end

   // configuration hold crosses into the core side
   cts_sync u_hold (
      .i_clk  (i_clk),
      .i_nrst (i_nrst),
      .i_wr   (wr_en && i_wb_adr == ADR_CORE_CTRL && i_wb_sel[0]),
      .i_val  (i_wb_dat[CFG_HOLD_BIT]),
      .o_val  (hold_val),
      .o_busy (hold_busy)
   );

   // clock stop request and its acknowledge
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         clock_stop_request <= 1'b0;
         clock_stop_ack     <= 1'b0;
      end else begin
         if (wr_en && i_wb_adr == ADR_CORE_CTRL && i_wb_sel[0]) begin
            clock_stop_request <= i_wb_dat[CLK_STOP_REQ_BIT];
         end
         // software owns clock gating before it clears the request
         // ack follows the request once hold is not mid-transfer
         if (!hold_busy) begin
            clock_stop_ack <= clock_stop_request;
         end
      end
   end

   assign stop_exit = clock_stop_ack && !clock_stop_request && !hold_busy;

   always_comb begin
      core_ctrl                   = '0;
      core_ctrl[CFG_HOLD_BIT]     = hold_val;
      core_ctrl[CLK_STOP_ACK_BIT] = clock_stop_ack;
      core_ctrl[CLK_STOP_REQ_BIT] = clock_stop_request;
   end

   // stamp configuration and buffer configuration
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         stamp_prescale         <= 4'h0;
         stamp_source_select    <= 2'h0;
         transmit_buffer_config <= 32'h0000_0000;
      end else if (wr_en) begin
         if (i_wb_adr == ADR_STAMP_CFG) begin
            if (i_wb_sel[2]) begin
               stamp_prescale <= i_wb_dat[PRESCALE_LSB +: 4];
            end
            if (i_wb_sel[0]) begin
               stamp_source_select <= i_wb_dat[SRC_LSB +: 2];
            end
         end
         if (i_wb_adr == ADR_BUF_CONFIG) begin
            transmit_buffer_config <= merge(transmit_buffer_config, i_wb_dat, wmask);
         end
      end
   end

   cts_stamp u_stamp (
      .i_clk      (i_clk),
      .i_nrst     (i_nrst),
      .i_bit_tick (i_bit_tick),
      .i_prescale (stamp_prescale),
      .i_src      (stamp_source_select),
      .i_clear_wr (wr_en && i_wb_adr == ADR_STAMP_VAL),
      .o_value    (stamp_value),
      .o_wrap     (stamp_wrap)
   );

   // transmit add request: set by one while a scan runs, cleared by scan completion
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         transmit_add_request <= 32'h0000_0000;
      end else begin
         if (!i_scan_busy) begin
            transmit_add_request <= 32'h0000_0000;
         end else begin
            transmit_add_request <= transmit_add_request & ~i_scan_done;
         end
         if (wr_en && i_wb_adr == ADR_TX_ADD_REQ && i_scan_busy) begin
            // a one sets, a zero leaves the bit alone
            transmit_add_request <= (transmit_add_request & ~i_scan_done)
                                  | (i_wb_dat & wmask & transmit_buffer_config);
         end
      end
   end

   // requests reach the engine even when no scan holds them
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_tx_request <= 32'h0000_0000;
      end else if (wr_en && i_wb_adr == ADR_TX_ADD_REQ) begin
         o_tx_request <= i_wb_dat & wmask & transmit_buffer_config;
      end else begin
         o_tx_request <= 32'h0000_0000;
      end
   end

   // interrupts: set wins over write-one-to-clear
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_status <= 2'h0;
         irq_mask   <= 2'h0;
      end else begin
         if (wr_en && i_wb_adr == ADR_IRQ_STATUS && i_wb_sel[0]) begin
            irq_status <= (irq_status & ~i_wb_dat[1:0])
                        | (stamp_wrap ? IRQ_WRAP : 2'h0)
                        | (stop_exit ? IRQ_STOP_EXIT : 2'h0);
         end else begin
            irq_status <= irq_status
                        | (stamp_wrap ? IRQ_WRAP : 2'h0)
                        | (stop_exit ? IRQ_STOP_EXIT : 2'h0);
         end
         if (wr_en && i_wb_adr == ADR_IRQ_MASK && i_wb_sel[0]) begin
            irq_mask <= i_wb_dat[1:0];
         end
      end
   end

   // read mux, unmapped reads return zero
   always_comb begin
      case (i_wb_adr)
         ADR_CORE_CTRL:  next_rdata = core_ctrl;
         ADR_STAMP_CFG:  next_rdata = {12'h000, stamp_prescale, 14'h0000,
                                       stamp_source_select};
         ADR_STAMP_VAL:  next_rdata = {16'h0000, stamp_value};
         ADR_IRQ_STATUS: next_rdata = {30'h0000_0000, irq_status};
         ADR_IRQ_MASK:   next_rdata = {30'h0000_0000, irq_mask};
         ADR_BUF_CONFIG: next_rdata = transmit_buffer_config;
         ADR_TX_ADD_REQ: next_rdata = transmit_add_request;
         default:        next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_wb_dat       <= 32'h0000_0000;
         o_cfg_hold     <= 1'b1;
         o_clk_stop_ack <= 1'b0;
         o_irq          <= 1'b0;
      end else begin
         o_wb_dat       <= next_rdata;
         o_cfg_hold     <= hold_val;
         o_clk_stop_ack <= clock_stop_ack;
         o_irq          <= |(irq_status & irq_mask);
      end
   end
endmodule : cts_top

/* cts_top_bench.sv */
// Purpose: self-checking bench for the can timestamp and tx request block
// Assumes: frame model ticks every clock, so a wrap takes 65536 cycles
// Notes:   stamp reads allow one count of slack for prescaler phase
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; \
   $display("unexpected at %0t: %h vs %h", $time, (a), (e)); end end
module cts_top_bench;
   import cts_pkg::*;
   logic i_clk = 0, i_nrst = 0, cyc = 0, stb = 0, we = 0, kick = 0, seen_clr = 0;
   logic [7:0] adr = 0;
   logic [3:0] sel = 0;
   logic [31:0] dat = 0, rd, v1, c, v, txseen = 0, tx_req, wb_dat, done;
   logic ack, hold, sack, irq, tick, busy, b;
   int err_count = 0, n_checks = 0, seed = 99, p, s, dt, n;
   int srcs[4] = '{1, 2, 0, 3};
   realtime t1;
   always #10 i_clk = ~i_clk;
   // one process owns the pulse collector, cleared by a strobe from the stimulus
   always @(posedge i_clk) txseen <= seen_clr ? 32'h0 : (txseen | tx_req);
   cts_top dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(wb_dat),
      .o_wb_ack(ack), .i_bit_tick(tick), .i_scan_busy(busy), .i_scan_done(done),
      .o_tx_request(tx_req), .o_cfg_hold(hold), .o_clk_stop_ack(sack), .o_irq(irq));
   cts_frame_model #(.DIV(1), .SCAN(40)) far_u (.i_clk(i_clk), .i_nrst(i_nrst),
      .i_kick(kick), .i_req(tx_req), .o_tick(tick), .o_busy(busy), .o_done(done));
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge i_clk);
      {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hf};
      k = 0;
      do begin @(posedge i_clk); k++; end while (ack !== 1'b1 && k < 20);
      if (k >= 20) err_count++;
      rd = wb_dat;
      {cyc, stb, we} <= 3'b000;
   endtask : wb
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask : rdchk
   function automatic logic [31:0] exp_req(logic [31:0] val, logic [31:0] cfg, logic bz);
      return bz ? (val & cfg) : 32'h0;
   endfunction : exp_req
   // src 1 counts ticks over prescale+1, src 2 holds, others stay at zero
   function automatic logic stamp_ok(logic [31:0] a, logic [31:0] z, int d, int ps, int sr);
      int want;
      want = int'(a[15:0]) + d / (ps + 1);
      if (sr == 1) return int'(z) >= want - 1 && int'(z) <= want + 1;
      if (sr == 2) return z === a;
      return z === 32'h0 && a === 32'h0;
   endfunction : stamp_ok
   task complete_run;
      if (err_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run
   initial begin
      // about 67k cycles of tests, wrap wait included, plus margin
      #1_700_000;
      err_count++;
      complete_run();
   end
   initial begin
      repeat (4) @(posedge i_clk);
      i_nrst <= 1'b1;
      `CHK(hold, 1'b1)
      rdchk(ADR_CORE_CTRL, CORE_CTRL_RST);
      rdchk(ADR_STAMP_VAL, 32'h0);
      rdchk(ADR_TX_ADD_REQ, 32'h0);
      wb(1'b1, 8'h30, 32'hffff_ffff);
      rdchk(8'h30, 32'h0);
      wb(1'b1, ADR_IRQ_MASK, 32'h3);
      wb(1'b1, ADR_CORE_CTRL, 32'h11);
      repeat (10) @(posedge i_clk);
      `CHK(sack, 1'b1)
      wb(1'b1, ADR_CORE_CTRL, 32'h1);
      repeat (10) @(posedge i_clk);
      `CHK(sack, 1'b0)
      `CHK(irq, 1'b1)
      wb(1'b1, ADR_IRQ_STATUS, {30'h0, IRQ_STOP_EXIT});
      repeat (2) @(posedge i_clk);
      `CHK(irq, 1'b0)
      wb(1'b1, ADR_CORE_CTRL, 32'h0);
      rdchk(ADR_CORE_CTRL, 32'h1);
      repeat (10) @(posedge i_clk);
      rdchk(ADR_CORE_CTRL, 32'h0);
      `CHK(hold, 1'b0)
      foreach (srcs[j]) begin
         s = srcs[j];
         p = $unsigned($random(seed)) % 4;
         wb(1'b1, ADR_STAMP_CFG, (32'(p) << PRESCALE_LSB) | 32'(s));
         repeat (20) @(posedge i_clk);
         wb(1'b0, ADR_STAMP_VAL, 32'h0);
         v1 = rd;
         t1 = $realtime;
         repeat (30) @(posedge i_clk);
         wb(1'b0, ADR_STAMP_VAL, 32'h0);
         dt = int'(($realtime - t1) / 20.0);
         `CHK(stamp_ok(v1, rd, dt, p, s), 1'b1)
         v1 = rd;
         wb(1'b1, ADR_STAMP_VAL, 32'hffff_ffff);
         wb(1'b0, ADR_STAMP_VAL, 32'h0);
         `CHK(s == 1 ? rd < 32'h4 : rd === (s == 2 ? v1 : 32'h0), 1'b1)
         wb(1'b0, ADR_IRQ_STATUS, 32'h0);
         `CHK(rd[0], 1'b0)
      end
      wb(1'b1, ADR_STAMP_CFG, 32'h1);
      wb(1'b1, ADR_STAMP_VAL, 32'h0);
      wb(1'b1, ADR_IRQ_MASK, 32'h1);
      repeat (65000) @(posedge i_clk);
      `CHK(irq, 1'b0)
      n = 0;
      while (irq !== 1'b1 && n < 1000) begin @(posedge i_clk); n++; end
      `CHK(irq, 1'b1)
      rdchk(ADR_IRQ_STATUS, {30'h0, IRQ_WRAP});
      wb(1'b1, ADR_STAMP_CFG, 32'h0);
      wb(1'b1, ADR_IRQ_STATUS, 32'h3);
      repeat (2) @(posedge i_clk);
      `CHK(irq, 1'b0)
      for (int i = 0; i < 8; i++) begin
         c = (i == 1) ? 32'hffff_ffff : $random(seed);
         v = (i == 0) ? 32'h0 : $random(seed);
         b = i[0];
         wb(1'b1, ADR_BUF_CONFIG, c);
         kick     <= b;
         seen_clr <= 1'b1;
         @(posedge i_clk);
         kick     <= 1'b0;
         seen_clr <= 1'b0;
         wb(1'b1, ADR_TX_ADD_REQ, v);
         repeat (3) @(posedge i_clk);
         `CHK(txseen, v & c)
         rdchk(ADR_TX_ADD_REQ, exp_req(v, c, b));
         repeat (45) @(posedge i_clk);
         rdchk(ADR_TX_ADD_REQ, 32'h0);
      end
      complete_run();
   end
endmodule : cts_top_bench
